/* File: pkg/tmr16_regs.svh */
// Register offsets, field positions, reset values and divider taps of the 16-bit timer.
`ifndef TMR16_REGS_SVH
`define TMR16_REGS_SVH
`define TMR16_OFF_CTRL_A 8'h00
`define TMR16_OFF_CTRL_B 8'h04
`define TMR16_OFF_CNT_L  8'h08
`define TMR16_OFF_CNT_H  8'h0c
`define TMR16_OFF_CMPA_L 8'h10
`define TMR16_OFF_CMPA_H 8'h14
`define TMR16_OFF_CMPB_L 8'h18
`define TMR16_OFF_CMPB_H 8'h1c
`define TMR16_OFF_CAP_L  8'h20
`define TMR16_OFF_CAP_H  8'h24
`define TMR16_OFF_FLAG   8'h28
`define TMR16_OFF_MASK   8'h2c
`define TMR16_OFF_POWER  8'h30
`define TMR16_CA_MODE_LSB 0
`define TMR16_CA_OUTA_EN  4
`define TMR16_CA_OUTB_EN  5
`define TMR16_CB_SEL_LSB  0
`define TMR16_CB_CAP_SRC  5
`define TMR16_CB_CAP_EDGE 6
`define TMR16_CB_FILT_EN  7
`define TMR16_FLAG_OVF  0
`define TMR16_FLAG_CMPA 1
`define TMR16_FLAG_CMPB 2
`define TMR16_FLAG_CAP  3
`define TMR16_MODE_MAX   3'h0
`define TMR16_MODE_FF    3'h1
`define TMR16_MODE_1FF   3'h2
`define TMR16_MODE_3FF   3'h3
`define TMR16_MODE_CMPA  3'h4
`define TMR16_MODE_CAP   3'h5
`define TMR16_MODE_PCMPA 3'h6
`define TMR16_MODE_PCAP  3'h7
`define TMR16_TOP_FF    16'h00ff
`define TMR16_TOP_1FF   16'h01ff
`define TMR16_TOP_3FF   16'h03ff
`define TMR16_TOP_MAX   16'hffff
`define TMR16_BOTTOM    16'h0000
`define TMR16_RST_POWER 8'h01
`define TMR16_PRE_W     10
`endif

/* File: pkg/tmr16_pkg.sv */
// Types shared by the 16-bit timer modules.
package tmr16_pkg;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } tmr16_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } tmr16_apb_rsp_t;
   typedef struct packed {
      tmr16_apb_rsp_t rsp;
      logic [7:0]     ctrlA;
      logic [7:0]     ctrlB;
      logic [7:0]     power;
      logic [7:0]     temp;
      logic [15:0]    cnt;
      logic [15:0]    bufA;
      logic [15:0]    bufB;
      logic [15:0]    actA;
      logic [15:0]    actB;
      logic [15:0]    cap;
      logic [3:0]     flag;
      logic [3:0]     mask;
      logic [3:0]     intReq;
      logic           outA;
      logic           outB;
      logic           atBottom;
      logic           atMax;
      logic           atTop;
   } tmr16_state_t;
   typedef struct packed {
      logic [9:0] prescale;
      logic       extLast;
   } tmr16_tick_st_t;
   typedef struct packed {
      logic [3:0] hist;
      logic       filtered;
      logic       last;
   } tmr16_cap_st_t;
endpackage

/* File: design/tmr16_tick_sel.sv */
// Timer tick source selection: prescaler taps or external pin edges.
`timescale 1ns/1ps
`include "tmr16_regs.svh"
module tmr16_tick_sel (
   // Clock and reset.
   input  wire logic       clock,
   input  wire logic       rstSync_b,
   // Selection.
   input  wire logic       enable,
   input  wire logic [2:0] clockSel,
   input  wire logic       extPin,
   // Tick.
   output logic            tick
);
   import tmr16_pkg::*;
   tmr16_tick_st_t q_ff;
   tmr16_tick_st_t nxt_q;

   function automatic logic tapAt(input logic [9:0] pre, input int w);
      logic [9:0] m;
      m = 10'((1 << w) - 1);
      return (pre & m) == m;
   endfunction

   always_comb begin
      nxt_q = q_ff;
      nxt_q.prescale = enable ? q_ff.prescale + 10'h001 : 10'h000;
      nxt_q.extLast = extPin;
      tick = 1'b0;
      if (enable) begin
         unique case (clockSel)
            3'h0: tick = 1'b0;
            3'h1: tick = 1'b1;
            3'h2: tick = tapAt(q_ff.prescale, 3);
            3'h3: tick = tapAt(q_ff.prescale, 6);
            3'h4: tick = tapAt(q_ff.prescale, 8);
            3'h5: tick = tapAt(q_ff.prescale, `TMR16_PRE_W);
            3'h6: tick = q_ff.extLast & ~extPin;
            3'h7: tick = ~q_ff.extLast & extPin;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstSync_b) begin
      if (!rstSync_b) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end
endmodule

/* File: design/tmr16_capture.sv */
// Capture trigger: source select, four-sample noise filter and edge detector.
`timescale 1ns/1ps
module tmr16_capture (
   // Clock and reset.
   input  wire logic clock,
   input  wire logic rstSync_b,
   // Inputs and settings.
   input  wire logic enable,
   input  wire logic pinIn,
   input  wire logic cmpIn,
   input  wire logic srcSel,
   input  wire logic edgeSel,
   input  wire logic filterEn,
   // Event.
   output logic      capEvent
);
   import tmr16_pkg::*;
   tmr16_cap_st_t q_ff;
   tmr16_cap_st_t nxt_q;
   logic          raw;
   logic          level;

   always_comb begin
      nxt_q = q_ff;
      raw = srcSel ? cmpIn : pinIn;
      nxt_q.hist = {q_ff.hist[2:0], raw};
      // The filtered level moves only after four equal samples.
      if (q_ff.hist == 4'hf) begin
         nxt_q.filtered = 1'b1;
      end else if (q_ff.hist == 4'h0) begin
         nxt_q.filtered = 1'b0;
      end
      level = filterEn ? q_ff.filtered : q_ff.hist[0];
      nxt_q.last = level;
      capEvent = enable & (edgeSel ? (level & ~q_ff.last) : (~level & q_ff.last));
   end

   always_ff @(posedge clock or negedge rstSync_b) begin
      if (!rstSync_b) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end
endmodule

/* File: design/tmr16_core.sv */
// Top of the 16-bit timer: APB slave, byte-wide access to 16-bit registers, counter, compare and capture.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "tmr16_regs.svh"
module tmr16_core (
   // Clock and reset.
   input  wire logic                     clock,
   input  wire logic                     rst_b,
   // APB register bus.
   input  wire tmr16_pkg::tmr16_apb_req_t apbReq,
   output tmr16_pkg::tmr16_apb_rsp_t      apbRsp,
   // Timer pins.
   input  wire logic                     externalTickPin,
   input  wire logic                     captureInputPin,
   input  wire logic                     comparatorOut,
   output logic                          compareOutputPinA,
   output logic                          compareOutputPinB,
   // Counter status and masked requests.
   output logic                          atBottom,
   output logic                          atMax,
   output logic                          atTop,
   output logic [3:0]                    intReq
);
   import tmr16_pkg::*;
   logic [1:0]   rstPipe_ff;
   logic         rstSync_b;
   tmr16_state_t q_ff;
   tmr16_state_t nxt_q;
   logic         tick;
   logic         capEvent;
   logic         enable;
   logic [2:0]   mode;
   logic [15:0]  top;
   logic         setup;
   logic         access;
   logic [7:0]   wbyte;
   logic         wrap;
   logic         matchA;
   logic         matchB;
   logic [3:0]   setFlag;
   logic [3:0]   flagClr;

   function automatic logic isPwm(input logic [2:0] m);
      return (m == `TMR16_MODE_FF) || (m == `TMR16_MODE_1FF) || (m == `TMR16_MODE_3FF) ||
             (m == `TMR16_MODE_PCMPA) || (m == `TMR16_MODE_PCAP);
   endfunction

   function automatic logic capIsTop(input logic [2:0] m);
      return (m == `TMR16_MODE_CAP) || (m == `TMR16_MODE_PCAP);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= `TMR16_OFF_POWER);
   endfunction

   // Joins the staged high byte with the low byte being written.
   function automatic logic [15:0] merge16(input logic [7:0] hi, input logic [7:0] lo);
      return {hi, lo};
   endfunction

   // Reset enters at once but leaves through two flops, so every register reset by rstSync_b leaves it on one edge.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rstPipe_ff <= 2'h0;
      end else begin
         rstPipe_ff <= {rstPipe_ff[0], 1'b1};
      end
   end
   assign rstSync_b = rstPipe_ff[1];

   // A set power gate bit stops the tick and the capture input.
   assign enable = ~q_ff.power[0];
   assign mode   = q_ff.ctrlA[`TMR16_CA_MODE_LSB +: 3];

   tmr16_tick_sel u_tick (
      .clock     (clock),
      .rstSync_b (rstSync_b),
      .enable    (enable),
      .clockSel  (q_ff.ctrlB[`TMR16_CB_SEL_LSB +: 3]),
      .extPin    (externalTickPin),
      .tick      (tick)
   );

   // Capture input is off while the capture register defines top.
   tmr16_capture u_cap (
      .clock     (clock),
      .rstSync_b (rstSync_b),
      .enable    (enable & ~capIsTop(mode)),
      .pinIn     (captureInputPin),
      .cmpIn     (comparatorOut),
      .srcSel    (q_ff.ctrlB[`TMR16_CB_CAP_SRC]),
      .edgeSel   (q_ff.ctrlB[`TMR16_CB_CAP_EDGE]),
      .filterEn  (q_ff.ctrlB[`TMR16_CB_FILT_EN]),
      .capEvent  (capEvent)
   );

   always_comb begin
      nxt_q = q_ff;
      // Top of the count sequence for the selected mode.
      unique case (mode)
         `TMR16_MODE_MAX:   top = `TMR16_TOP_MAX;
         `TMR16_MODE_FF:    top = `TMR16_TOP_FF;
         `TMR16_MODE_1FF:   top = `TMR16_TOP_1FF;
         `TMR16_MODE_3FF:   top = `TMR16_TOP_3FF;
         `TMR16_MODE_CMPA:  top = q_ff.actA;
         `TMR16_MODE_CAP:   top = q_ff.cap;
         `TMR16_MODE_PCMPA: top = q_ff.actA;
         `TMR16_MODE_PCAP:  top = q_ff.cap;
      endcase
      setup  = apbReq.psel & ~apbReq.penable;
      access = apbReq.psel & apbReq.penable & q_ff.rsp.pready;
      wbyte  = apbReq.pwdata[7:0];
      wrap   = tick & (q_ff.cnt == top);
      matchA = tick & (q_ff.cnt == q_ff.actA);
      matchB = tick & (q_ff.cnt == q_ff.actB);
      setFlag = 4'h0;
      flagClr = 4'h0;

      // At top the counter wraps to bottom and raises the overflow flag.
      // Counting; a counter write further down overrides it.
      if (tick) begin
         nxt_q.cnt = wrap ? `TMR16_BOTTOM : q_ff.cnt + 16'h0001;
      end
      setFlag[`TMR16_FLAG_OVF]  = wrap;
      setFlag[`TMR16_FLAG_CMPA] = matchA;
      setFlag[`TMR16_FLAG_CMPB] = matchB;

      // Waveform: toggle on match, or set at wrap and clear on match in PWM modes.
      if (isPwm(mode)) begin
         if (wrap) begin
            nxt_q.outA = 1'b1;
            nxt_q.outB = 1'b1;
            nxt_q.actA = q_ff.bufA;
            nxt_q.actB = q_ff.bufB;
         end
         if (matchA) begin
            nxt_q.outA = 1'b0;
         end
         if (matchB) begin
            nxt_q.outB = 1'b0;
         end
      end else begin
         if (matchA) begin
            nxt_q.outA = ~q_ff.outA;
         end
         if (matchB) begin
            nxt_q.outB = ~q_ff.outB;
         end
      end
      if (!q_ff.ctrlA[`TMR16_CA_OUTA_EN] || mode == `TMR16_MODE_PCMPA) begin
         nxt_q.outA = 1'b0;
      end
      if (!q_ff.ctrlA[`TMR16_CA_OUTB_EN]) begin
         nxt_q.outB = 1'b0;
      end

      if (capEvent) begin
         nxt_q.cap = q_ff.cnt;
      end
      setFlag[`TMR16_FLAG_CAP] = capEvent;

      // Bus setup cycle: answer is prepared, read side effects happen here.
      nxt_q.rsp.pready  = setup;
      nxt_q.rsp.pslverr = setup & ~mapped(apbReq.paddr);
      if (setup) begin
         nxt_q.rsp.prdata = 32'h0000_0000;
         if (!apbReq.pwrite) begin
            unique case (apbReq.paddr)
               `TMR16_OFF_CTRL_A: nxt_q.rsp.prdata[7:0] = q_ff.ctrlA;
               `TMR16_OFF_CTRL_B: nxt_q.rsp.prdata[7:0] = q_ff.ctrlB;
               `TMR16_OFF_CNT_L: begin
                  nxt_q.rsp.prdata[7:0] = q_ff.cnt[7:0];
                  nxt_q.temp = q_ff.cnt[15:8];
               end
               `TMR16_OFF_CNT_H: begin
                  nxt_q.rsp.prdata[7:0] = q_ff.temp;
               end
               `TMR16_OFF_CMPA_L: nxt_q.rsp.prdata[7:0] = q_ff.bufA[7:0];
               `TMR16_OFF_CMPA_H: begin
                  nxt_q.rsp.prdata[7:0] = q_ff.bufA[15:8];
               end
               `TMR16_OFF_CMPB_L: nxt_q.rsp.prdata[7:0] = q_ff.bufB[7:0];
               `TMR16_OFF_CMPB_H: begin
                  nxt_q.rsp.prdata[7:0] = q_ff.bufB[15:8];
               end
               `TMR16_OFF_CAP_L: begin
                  nxt_q.rsp.prdata[7:0] = q_ff.cap[7:0];
                  nxt_q.temp = q_ff.cap[15:8];
               end
               `TMR16_OFF_CAP_H: begin
                  nxt_q.rsp.prdata[7:0] = q_ff.temp;
               end
               `TMR16_OFF_FLAG:  nxt_q.rsp.prdata[3:0] = q_ff.flag;
               `TMR16_OFF_MASK:  nxt_q.rsp.prdata[3:0] = q_ff.mask;
               `TMR16_OFF_POWER: nxt_q.rsp.prdata[7:0] = q_ff.power;
               default:          nxt_q.rsp.prdata = 32'h0000_0000;
            endcase
         end
      end

      // Bus access cycle: writes take effect at its completing edge.
      if (access && apbReq.pwrite) begin
         unique case (apbReq.paddr)
            `TMR16_OFF_CTRL_A: begin
               nxt_q.ctrlA = wbyte;
            end
            `TMR16_OFF_CTRL_B: begin
               nxt_q.ctrlB = wbyte;
            end
            `TMR16_OFF_CNT_H,
            `TMR16_OFF_CMPA_H,
            `TMR16_OFF_CMPB_H,
            `TMR16_OFF_CAP_H: begin
               nxt_q.temp = wbyte;
            end
            // The holding register is left as it is, so one high byte serves many low writes.
            `TMR16_OFF_CNT_L: begin
               nxt_q.cnt = merge16(q_ff.temp, wbyte);
            end
            `TMR16_OFF_CMPA_L: begin
               nxt_q.bufA = merge16(q_ff.temp, wbyte);
               // In PWM modes the active copy follows only at the wrap, so top never jumps mid-period.
               if (!isPwm(mode)) begin
                  nxt_q.actA = merge16(q_ff.temp, wbyte);
               end
            end
            `TMR16_OFF_CMPB_L: begin
               nxt_q.bufB = merge16(q_ff.temp, wbyte);
               if (!isPwm(mode)) begin
                  nxt_q.actB = merge16(q_ff.temp, wbyte);
               end
            end
            // Capture is writable only while it defines top.
            `TMR16_OFF_CAP_L: begin
               if (capIsTop(mode)) begin
                  nxt_q.cap = merge16(q_ff.temp, wbyte);
               end
            end
            `TMR16_OFF_FLAG: begin
               flagClr = wbyte[3:0];
            end
            `TMR16_OFF_MASK: begin
               nxt_q.mask = wbyte[3:0];
            end
            `TMR16_OFF_POWER: begin
               nxt_q.power = {7'h00, wbyte[0]};
            end
            default: begin
               nxt_q.temp = q_ff.temp;
            end
         endcase
      end

      // A new event wins over a clear in the same cycle.
      for (int i = 0; i < 4; i++) begin
         nxt_q.flag[i] = setFlag[i] | (q_ff.flag[i] & ~flagClr[i]);
      end
      nxt_q.intReq = nxt_q.flag & nxt_q.mask;
      // Status bits follow the value the counter holds after this edge.
      nxt_q.atBottom = nxt_q.cnt == `TMR16_BOTTOM;
      nxt_q.atMax    = nxt_q.cnt == `TMR16_TOP_MAX;
      nxt_q.atTop    = nxt_q.cnt == top;
   end

   // Reset clears all but the power gate, which starts closed, and the bottom status.
   always_ff @(posedge clock or negedge rstSync_b) begin
      if (!rstSync_b) begin
         q_ff <= '0;
         q_ff.power <= `TMR16_RST_POWER;
         q_ff.atBottom <= 1'b1;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // Every output is a register bit, so nothing combinational reaches a pin.
   assign apbRsp            = q_ff.rsp;
   assign compareOutputPinA = q_ff.outA;
   assign compareOutputPinB = q_ff.outB;
   assign atBottom          = q_ff.atBottom;
   assign atMax             = q_ff.atMax;
   assign atTop             = q_ff.atTop;
   assign intReq            = q_ff.intReq;
endmodule

/* File: test/tmr16_cpu_model.sv */
// Behavioural CPU that reaches the timer registers a byte at a time.
`timescale 1ns/1ps
module tmr16_cpu_model
   import tmr16_pkg::*;
(
   // Bus.
   input  wire logic                      clock,
   output tmr16_pkg::tmr16_apb_req_t      req,
   input  wire tmr16_pkg::tmr16_apb_rsp_t rsp
);
   initial req = '0;
   // Transfers never overlap, so nothing can slip between the two byte accesses.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clock);
      req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
      @(posedge clock);
      req.penable <= 1'b1;
      do @(posedge clock); while (rsp.pready !== 1'b1);
      q = rsp.prdata[7:0];
      req <= '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      xfer(1'b0, a, 8'h00, q);
   endtask
   // High byte goes first on a write, low byte first on a read.
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      wr(a + 8'h04, v[15:8]);
      wr(a, v[7:0]);
   endtask
   task automatic rd16(input logic [7:0] a, output logic [15:0] v);
      rd(a, v[7:0]);
      rd(a + 8'h04, v[15:8]);
   endtask
endmodule

/* File: test/tmr16_core_properties.sv */
// Bus and status assertions for the 16-bit timer top.
`timescale 1ns/1ps
`include "tmr16_regs.svh"
module tmr16_core_properties
   import tmr16_pkg::*;
(
   // Watched ports.
   input wire logic                      clock,
   input wire logic                      rst_b,
   input wire tmr16_pkg::tmr16_apb_req_t apbReq,
   input wire tmr16_pkg::tmr16_apb_rsp_t apbRsp,
   input wire logic                      compareOutputPinA,
   input wire logic                      atBottom,
   input wire logic                      atMax,
   input wire logic [3:0]                intReq
);
   logic       setup;
   logic       done;
   logic [2:0] modeSeen_ff;
   assign setup = apbReq.psel && !apbReq.penable;
   assign done  = apbReq.psel && apbReq.penable && apbRsp.pready;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         modeSeen_ff <= 3'h0;
      end else if (done && apbReq.pwrite && apbReq.paddr == `TMR16_OFF_CTRL_A) begin
         modeSeen_ff <= apbReq.pwdata[2:0];
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   a_ready_after_setup: assert property (setup |=> apbRsp.pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (apbRsp.pready |=> !apbRsp.pready)
      else $error("ready held too long");
   a_ready_needs_setup: assert property (apbRsp.pready |-> $past(setup))
      else $error("ready without setup");
   a_misaligned_err: assert property (setup && apbReq.paddr[1:0] != 2'h0 |=> apbRsp.pslverr)
      else $error("no error on misaligned address");
   a_rdata_holds: assert property ($changed(apbRsp.prdata) |-> $past(setup))
      else $error("read data moved without setup");
   a_mask_silences: assert property (done && apbReq.pwrite && apbReq.paddr == `TMR16_OFF_MASK
      && apbReq.pwdata[3:0] == 4'h0 |=> ##1 intReq == 4'h0)
      else $error("request seen while all masked");
   a_pwm_a_quiet: assert property (modeSeen_ff == `TMR16_MODE_PCMPA
      && $past(modeSeen_ff) == `TMR16_MODE_PCMPA |-> !compareOutputPinA)
      else $error("output A active with compare A as top");
   a_max_not_bottom: assert property (atMax |-> !atBottom)
      else $error("maximum and bottom together");
   c_write_done: cover property (done && apbReq.pwrite);
   c_read_done: cover property (done && !apbReq.pwrite);
   c_request: cover property (intReq != 4'h0);
endmodule
bind tmr16_core tmr16_core_properties u_props (
   .clock             (clock),
   .rst_b             (rst_b),
   .apbReq            (apbReq),
   .apbRsp            (apbRsp),
   .compareOutputPinA (compareOutputPinA),
   .atBottom          (atBottom),
   .atMax             (atMax),
   .intReq            (intReq)
);

/* File: test/tb_timer16_core_byte_access.sv */
// Self-checking bench for the 16-bit timer with byte-wide register access.
`timescale 1ns/1ps
`include "tmr16_regs.svh"
module tb_timer16_core_byte_access;
   import tmr16_pkg::*;
   logic           clock;
   logic           rst_b;
   logic           extPin;
   logic           capPin;
   logic           cmpPin;
   logic           pinA;
   logic           pinB;
   logic           atBot;
   logic           atMx;
   logic           atTp;
   logic [3:0]     irq;
   logic [7:0]     q;
   logic [15:0]    v;
   logic [15:0]    w;
   tmr16_apb_req_t req;
   tmr16_apb_rsp_t rsp;
   int             failCount = 0;
   int             testsRun = 0;
   tmr16_core DUT (
      .clock             (clock),
      .rst_b             (rst_b),
      .apbReq            (req),
      .apbRsp            (rsp),
      .externalTickPin   (extPin),
      .captureInputPin   (capPin),
      .comparatorOut     (cmpPin),
      .compareOutputPinA (pinA),
      .compareOutputPinB (pinB),
      .atBottom          (atBot),
      .atMax             (atMx),
      .atTop             (atTp),
      .intReq            (irq)
   );
   tmr16_cpu_model cpu (
      .clock (clock),
      .req   (req),
      .rsp   (rsp)
   );
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      testsRun++;
      if (seen !== exp) begin
         failCount++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic tallyAndFinish();
      $display("comparisons %0d, mismatches %0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic t_reset();
      check(atBot, 1'b1);
      cpu.rd(`TMR16_OFF_CNT_H, q);
      check(q, 8'h00);
      for (int i = 0; i < 4; i++) begin
         cpu.rd16(`TMR16_OFF_CNT_L + 8'(i * 8), v);
         check(v, 16'h0000);
      end
      cpu.rd(`TMR16_OFF_POWER, q);
      check(q, `TMR16_RST_POWER);
      $display("end of reset test");
   endtask
   task automatic t_hold();
      cpu.wr16(`TMR16_OFF_CNT_L, 16'h1234);
      cpu.wr(`TMR16_OFF_CMPA_L, 8'h56);
      cpu.wr(`TMR16_OFF_CMPB_L, 8'h78);
      cpu.rd16(`TMR16_OFF_CNT_L, v);
      check(v, 16'h1234);
      cpu.wr(`TMR16_OFF_CNT_H, 8'h99);
      cpu.rd16(`TMR16_OFF_CMPA_L, v);
      check(v, 16'h1256);
      cpu.rd16(`TMR16_OFF_CMPB_L, v);
      check(v, 16'h1278);
      cpu.rd(`TMR16_OFF_CAP_H, q);
      check(q, 8'h99);
      cpu.rd(`TMR16_OFF_CAP_L, q);
      cpu.rd(`TMR16_OFF_CNT_H, q);
      check(q, 8'h00);
      cpu.rd(8'h09, q);
      check(q, 8'h00);
      $display("end of holding test");
   endtask
   task automatic t_gate();
      cpu.wr(`TMR16_OFF_CTRL_B, 8'h01);
      repeat (20) @(posedge clock);
      cpu.rd16(`TMR16_OFF_CNT_L, v);
      check(v, 16'h1234);
      cpu.wr(`TMR16_OFF_POWER, 8'h00);
      cpu.wr16(`TMR16_OFF_CNT_L, 16'h2000);
      cpu.rd16(`TMR16_OFF_CNT_L, v);
      check(v[15:8], 8'h20);
      check(v == 16'h2000, 1'b0);
      cpu.wr(`TMR16_OFF_CTRL_B, 8'h00);
      cpu.rd16(`TMR16_OFF_CNT_L, v);
      repeat (20) @(posedge clock);
      cpu.rd16(`TMR16_OFF_CNT_L, w);
      check(w, v);
      for (int s = 6; s < 8; s++) begin
         cpu.wr16(`TMR16_OFF_CNT_L, 16'h0000);
         cpu.wr(`TMR16_OFF_CTRL_B, 8'(s));
         repeat (5) begin
            extPin <= 1'b1;
            repeat (3) @(posedge clock);
            extPin <= 1'b0;
            repeat (3) @(posedge clock);
         end
         cpu.wr(`TMR16_OFF_CTRL_B, 8'h00);
         cpu.rd16(`TMR16_OFF_CNT_L, v);
         check(v, 16'h0005);
      end
      cpu.wr16(`TMR16_OFF_CNT_L, 16'h0000);
      cpu.wr(`TMR16_OFF_CTRL_B, 8'h02);
      repeat (80) @(posedge clock);
      cpu.wr(`TMR16_OFF_CTRL_B, 8'h00);
      cpu.rd16(`TMR16_OFF_CNT_L, v);
      check(v >= 16'h0009 && v <= 16'h000c, 1'b1);
      $display("end of tick test");
   endtask
   task automatic t_top();
      for (int m = 1; m < 4; m++) begin
         cpu.wr16(`TMR16_OFF_CNT_L, 16'h0000);
         cpu.wr(`TMR16_OFF_FLAG, 8'h0f);
         cpu.wr(`TMR16_OFF_CTRL_A, 8'(m));
         cpu.wr(`TMR16_OFF_CTRL_B, 8'h01);
         repeat (1100) @(posedge clock);
         cpu.wr(`TMR16_OFF_CTRL_B, 8'h00);
         cpu.rd16(`TMR16_OFF_CNT_L, v);
         check(v <= (16'h0080 << m) - 16'h0001, 1'b1);
         cpu.rd(`TMR16_OFF_FLAG, q);
         check(q[0], 1'b1);
      end
      cpu.wr(`TMR16_OFF_CTRL_A, 8'h00);
      cpu.wr16(`TMR16_OFF_CNT_L, 16'hffff);
      repeat (2) @(posedge clock);
      check({atMx, atBot, atTp}, 3'b101);
      $display("end of top test");
   endtask
   task automatic t_cmp();
      cpu.wr16(`TMR16_OFF_CNT_L, 16'h0000);
      cpu.wr16(`TMR16_OFF_CMPA_L, 16'h0020);
      cpu.wr(`TMR16_OFF_CTRL_A, 8'h10);
      cpu.wr(`TMR16_OFF_FLAG, 8'h0f);
      cpu.wr(`TMR16_OFF_MASK, 8'h02);
      cpu.wr(`TMR16_OFF_CTRL_B, 8'h01);
      for (int i = 0; i < 200 && irq[1] !== 1'b1; i++) @(posedge clock);
      check(irq, 4'h2);
      check(pinA, 1'b1);
      cpu.wr(`TMR16_OFF_MASK, 8'h00);
      cpu.rd(`TMR16_OFF_FLAG, q);
      check(q[1], 1'b1);
      cpu.wr(`TMR16_OFF_FLAG, 8'h02);
      cpu.rd(`TMR16_OFF_FLAG, q);
      check(q[1], 1'b0);
      cpu.wr(`TMR16_OFF_CTRL_A, 8'h16);
      repeat (300) @(posedge clock);
      check(pinA, 1'b0);
      check(pinB, 1'b0);
      $display("end of compare test");
   endtask
   task automatic t_cap();
      cpu.wr(`TMR16_OFF_CTRL_A, 8'h00);
      for (int s = 0; s < 2; s++) begin
         cpu.wr(`TMR16_OFF_CTRL_B, 8'hc0 | 8'(s << 5));
         cpu.wr16(`TMR16_OFF_CNT_L, 16'h4321 + 16'(s));
         cpu.wr(`TMR16_OFF_FLAG, 8'h0f);
         {cmpPin, capPin} <= {s == 1, 1'b1};
         repeat (12) @(posedge clock);
         cpu.rd16(`TMR16_OFF_CAP_L, v);
         check(v, 16'h4321 + 16'(s));
         cpu.rd(`TMR16_OFF_FLAG, q);
         check(q[3], 1'b1);
      end
      for (int m = 4; m < 6; m++) begin
         cpu.wr(`TMR16_OFF_CTRL_A, 8'(m));
         cpu.wr16(`TMR16_OFF_CAP_L, 16'h0040);
         cpu.wr16(`TMR16_OFF_CNT_L, 16'h0000);
         cpu.wr(`TMR16_OFF_FLAG, 8'h0f);
         cpu.wr(`TMR16_OFF_CTRL_B, 8'h01);
         repeat (150) @(posedge clock);
         cpu.wr(`TMR16_OFF_CTRL_B, 8'h00);
         cpu.rd16(`TMR16_OFF_CNT_L, v);
         check(v <= (m == 4 ? 16'h0020 : 16'h0040), 1'b1);
         cpu.rd16(`TMR16_OFF_CAP_L, v);
         check(v, m == 4 ? 16'h4322 : 16'h0040);
         cpu.rd(`TMR16_OFF_FLAG, q);
         check(q[0], 1'b1);
      end
      $display("end of capture test");
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      failCount++;
      tallyAndFinish();
   end
   initial begin
      rst_b = 1'b0;
      extPin = 1'b0;
      capPin = 1'b0;
      cmpPin = 1'b0;
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      repeat (3) @(posedge clock);
      t_reset();
      t_hold();
      t_gate();
      t_top();
      t_cmp();
      t_cap();
      tallyAndFinish();
   end
endmodule
